// ==== bench/ser_link_assertions.sv ====
// Purpose: Concurrent checks on the two-wire link between controller and read path.
// Assumes: SCL is made from clk, so clk samples every SCL phase.
// Notes: Helper logic counts bits and bytes after each start.
`timescale 1ns/10ps
`include "ser_defines.svh"
module ser_link_chk #(
  parameter logic [2:0] STRAP   = 3'h0,
  parameter int         QTR_CYC = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  localparam int START_MAX = QTR_CYC + 2;
  localparam int QUIET     = 4 * QTR_CYC;
  logic       scl_reg,  scl_next;
  logic       sda_reg,  sda_next;
  logic [3:0] bit_reg,  bit_next;
  logic [1:0] byte_reg, byte_next;
  logic [6:0] sh_reg,   sh_next;
  logic       rd_reg,   rd_next;
  logic       hit_reg,  hit_next;
  logic       rise;
  logic       start;
  logic       stop;
  logic       ninth;

  always_comb begin
    rise      = scl && !scl_reg;
    start     = scl && scl_reg && sda_reg && !sda;
    stop      = scl && scl_reg && !sda_reg && sda;
    ninth     = rise && (bit_reg == 4'h8);
    scl_next  = scl;
    sda_next  = sda;
    bit_next  = bit_reg;
    byte_next = byte_reg;
    sh_next   = sh_reg;
    rd_next   = rd_reg;
    hit_next  = hit_reg;
    if (start) begin
      bit_next  = 4'h0;
      byte_next = 2'h0;
      rd_next   = 1'b0;
      hit_next  = 1'b0;
    end else if (rise) begin
      sh_next  = {sh_reg[5:0], sda};
      bit_next = ninth ? 4'h0 : bit_reg + 4'h1;
      if (ninth && byte_reg != 2'h3) begin
        byte_next = byte_reg + 2'h1;
      end
      // The direction bit is on the line at the eighth rise of the address byte.
      if (bit_reg == 4'h7 && byte_reg == 2'h0) begin
        rd_next  = sda;
        hit_next = (sh_reg[6:3] == `SER_DEV_CODE) && (sh_reg[2:0] == STRAP);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_reg  <= 1'b1;
      sda_reg  <= 1'b1;
      bit_reg  <= 4'h0;
      byte_reg <= 2'h0;
      sh_reg   <= 7'h00;
      rd_reg   <= 1'b0;
      hit_reg  <= 1'b0;
    end else begin
      scl_reg  <= scl_next;
      sda_reg  <= sda_next;
      bit_reg  <= bit_next;
      byte_reg <= byte_next;
      sh_reg   <= sh_next;
      rd_reg   <= rd_next;
      hit_reg  <= hit_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  addr_ack_a: assert property (ninth && byte_reg == 2'h0 && hit_reg |-> !sda)
    else $error("matching address byte not acknowledged");
  sel_miss_a: assert property (ninth && byte_reg == 2'h0 && !hit_reg |-> sda)
    else $error("address with wrong select bits acknowledged");
  word_ack_a: assert property (ninth && hit_reg && !rd_reg
    && byte_reg inside {2'h1, 2'h2} |-> !sda)
    else $error("word address byte not acknowledged");
  host_turn_a: assert property (ninth && rd_reg && byte_reg != 2'h0 |-> !dev_sda_oe)
    else $error("device holds data line in controller acknowledge slot");
  nack_quiet_a: assert property (ninth && rd_reg && byte_reg != 2'h0 && sda
    |-> ##QUIET !dev_sda_oe)
    else $error("device drives after not acknowledged byte");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data line while clock high");
  no_fight_a: assert property (dev_sda_oe && scl
    |-> !host_sda_oe && !dev_sda_o && !host_sda_o)
    else $error("both ends drive data line while clock high");
  addr_listen_a: assert property (rise && byte_reg == 2'h0 && bit_reg != 4'h8
    |-> !dev_sda_oe)
    else $error("device drives during address bits");
  start_clk_a: assert property (scl && scl_reg && $rose(host_sda_oe)
    |-> ##[1:START_MAX] !scl)
    else $error("clock not lowered after start");
  stop_idle_a: assert property (stop |-> !dev_sda_oe ##1 scl [*8])
    else $error("link not idle after stop");
endmodule

// ==== bench/serial_eeprom_read_path_tb.sv ====
// Purpose: Self-checking bench joining controller and read path over the link.
// Assumes: Only preloaded addresses are read, since the array is not reset.
// Notes: A byte model with a counter predicts every returned byte.
`timescale 1ns/10ps
module serial_eeprom_read_path_tb;
  localparam int         QTR   = 10;
  localparam logic [2:0] STRAP = 3'h5;
  localparam int         LIMIT = 90000;
  logic        clk;
  logic        link_clk;
  logic        rst_n;
  logic        load_valid;
  logic        load_ready;
  logic [13:0] load_addr;
  logic [7:0]  load_data;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_random;
  logic [2:0]  cmd_sel;
  logic [13:0] cmd_addr;
  logic [7:0]  cmd_count;
  logic        rd_valid;
  logic [7:0]  rd_data;
  logic        done;
  logic        nack_err;
  int          error_cnt;
  int          n_compared;
  int          cycles = 0;
  int          ctr_m;
  logic [7:0]  mem_m [int];
  logic [7:0]  exp_q [$];

  ser_link_if link_if ();
  ser_eeprom_dev u_ser_eeprom_dev (
    .clk(clk), .link_clk(link_clk), .rst_n(rst_n), .chip_select_straps(STRAP),
    .load_valid(load_valid), .load_ready(load_ready), .load_addr(load_addr),
    .load_data(load_data), .link(link_if)
  );
  ser_host_ctrl #(.QTR_CYC(QTR)) u_ser_host_ctrl (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_random(cmd_random), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
    .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err), .link(link_if)
  );
  ser_link_chk #(.STRAP(STRAP), .QTR_CYC(QTR)) u_ser_link_chk (
    .clk(clk), .rst_n(rst_n), .scl(link_if.scl), .host_sda_o(link_if.host_sda_o),
    .host_sda_oe(link_if.host_sda_oe), .dev_sda_o(link_if.dev_sda_o),
    .dev_sda_oe(link_if.dev_sda_oe), .sda(link_if.sda)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d mismatches", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic preload(input logic [13:0] a, input logic [7:0] d);
    load_addr  = a;
    load_data  = d;
    load_valid = 1'b1;
    while (load_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    load_valid = 1'b0;
    mem_m[a]   = d;
    @(posedge clk);
    #1;
  endtask

  task automatic run_cmd(input logic rnd, input logic [2:0] sel, input logic [13:0] a,
                         input logic [7:0] n, input string name);
    int   wait_n;
    logic hit;
    hit = (sel == STRAP);
    if (rnd && hit) begin
      ctr_m = a;
    end
    for (int i = 0; hit && i < n; i++) begin
      exp_q.push_back(mem_m[ctr_m]);
      ctr_m = (ctr_m + 1) % 16384;
    end
    cmd_random = rnd;
    cmd_sel    = sel;
    cmd_addr   = a;
    cmd_count  = n;
    cmd_valid  = 1'b1;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    wait_n    = 0;
    while (done !== 1'b1 && wait_n < 20000) begin
      @(posedge clk);
      #1;
      wait_n++;
    end
    check({7'h0, done}, 8'h01, "done");
    check({7'h0, nack_err}, {7'h0, !hit}, "nack flag");
    check(8'(exp_q.size()), 8'h00, "bytes missing");
    exp_q.delete();
    $display("Test %s ended", name);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("BAD t=%0t unexpected byte %h", $time, rd_data);
      end else begin
        check(rd_data, exp_q.pop_front(), "read byte");
      end
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("BAD t=%0t run too long", $time);
      report_and_stop();
    end
  end

  initial begin
    rst_n      = 1'b0;
    load_valid = 1'b0;
    load_addr  = 14'h0000;
    load_data  = 8'h00;
    cmd_valid  = 1'b0;
    cmd_random = 1'b0;
    cmd_sel    = 3'h0;
    cmd_addr   = 14'h0000;
    cmd_count  = 8'h01;
    error_cnt  = 0;
    n_compared = 0;
    ctr_m      = 0;
    void'($urandom(32'hD0319A2D));
    repeat (4) @(posedge clk);
    check({6'h0, link_if.scl, link_if.sda}, 8'h03, "idle link");
    check({6'h0, cmd_ready, load_ready}, 8'h03, "idle ready");
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 22; i++) begin
      preload(i < 16 ? 14'(14'h0100 + i) : 14'(14'h3FFE + i - 16), 8'($urandom));
    end
    run_cmd(1'b1, STRAP, 14'h0100, 8'h01, "random single");
    run_cmd(1'b0, STRAP, 14'h0000, 8'h02, "current pair");
    run_cmd(1'b1, STRAP, 14'h3FFE, 8'h04, "top wrap");
    run_cmd(1'b0, STRAP, 14'h0000, 8'h01, "after wrap");
    run_cmd(1'b1, STRAP ^ 3'h2, 14'h0100, 8'h01, "random bad select");
    run_cmd(1'b0, STRAP ^ 3'h4, 14'h0000, 8'h01, "current bad select");
    run_cmd(1'b0, STRAP, 14'h0000, 8'h01, "counter kept");
    for (int k = 0; k < 4; k++) begin
      run_cmd(1'b1, STRAP, 14'(14'h0100 + $urandom % 12), 8'(1 + $urandom % 4), "mix");
    end
    run_cmd(1'b0, STRAP, 14'h0000, 8'h01, "current tail");
    report_and_stop();
  end
endmodule

// ==== logic/ser_defines.svh ====
// Purpose: Shared constants for the two-wire EEPROM read path and its controller.
// Assumes: Both ends include this header; types live in ser_pkg.
// Operation
// - Read form: address byte direction bit one.
// - Current, random and sequential reads supported.
// - Counter holds last accessed address plus one.
// - Counter kept between transactions while powered.
// - Read increment wraps last byte to first.
// - After read address acknowledge, send byte MSB-first.
// - Controller ends single read with NACK, stop.
// - Random read: dummy write loads word address.
// - Then repeated start and read-direction address.
// - Device acknowledges, sends byte at loaded address.
// - Controller acknowledges each byte wanting more.
// - Acknowledged byte: increment counter, send next.
// - Sequential read wraps at array top.
// - NACK plus stop ends; device releases data.
// - Eight-bit bytes, receiver pulls low ninth clock.
// - Select bits must match straps, else standby.
// - Data changes only while clock low.
// - Word address sent as two bytes.
`ifndef SER_DEFINES_SVH
`define SER_DEFINES_SVH
`define SER_ADDR_W       14
`define SER_DEV_CODE     4'hA
`define SER_DIR_READ     1'b1
`define SER_DIR_WRITE    1'b0
`define SER_BITS_BYTE    4'h8
`define SER_LAST_BIT     4'h7
`define SER_HI_W         6
`define SER_CLK_PERIOD_NS 25
`define SER_SCL_PERIOD_NS 10000
`define SER_QTR_CYC      ((`SER_SCL_PERIOD_NS / 4) / `SER_CLK_PERIOD_NS)
`endif

// ==== logic/ser_eeprom_dev.sv ====
// Purpose: Target end of the two-wire EEPROM read path with its byte array.
// Assumes: link_clk oversamples SCL and SDA; the array is preloaded from clk.
// Notes: Write data bytes are not taken; only the word address of a dummy write is.
`timescale 1ns/10ps
`include "ser_defines.svh"
module ser_eeprom_dev #(
  parameter int ADDR_W = `SER_ADDR_W
) (
  // Clocks and reset
  input  wire logic              clk,
  input  wire logic              link_clk,
  input  wire logic              rst_n,
  // Straps
  input  wire logic [2:0]        chip_select_straps,
  // Array preload, clk domain
  input  wire logic              load_valid,
  output logic                   load_ready,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [7:0]        load_data,
  // Link
  ser_link_if.dev                link
);
  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0]        mem [DEPTH];
  ser_pkg::ser_dev_st_e st_reg, st_next;
  logic [3:0]        bit_reg, bit_next;
  logic [7:0]        sh_reg, sh_next;
  logic [1:0]        idx_reg, idx_next;
  logic [`SER_HI_W-1:0] hi_reg, hi_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic              oe_reg, oe_next;
  logic              rw_reg, rw_next;
  logic              mack_reg, mack_next;
  logic              scl_m, scl_s, scl_d;
  logic              sda_m, sda_s, sda_d;
  logic [2:0]        str_m, str_s;
  logic              rise, fall, start_c, stop_c;

  // Preload handshake, clk side.
  logic              req_tog_reg, req_tog_next;
  logic [ADDR_W-1:0] la_reg, la_next;
  logic [7:0]        ld_reg, ld_next;
  logic              ack_m, ack_s;
  // Preload handshake, link side.
  logic              rq_m, rq_s, rq_d;

  // The held address and data stay still until the toggle returns, so the
  // link side may read them freely once its synchronised request changes.
  assign load_ready = (req_tog_reg == ack_s);

  always_comb begin
    req_tog_next = req_tog_reg;
    la_next = la_reg;
    ld_next = ld_reg;
    if (load_valid && load_ready) begin
      req_tog_next = !req_tog_reg;
      la_next = load_addr;
      ld_next = load_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_tog_reg <= 1'b0;
      la_reg <= '0;
      ld_reg <= 8'h00;
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      req_tog_reg <= req_tog_next;
      la_reg <= la_next;
      ld_reg <= ld_next;
      ack_m <= rq_d;
      ack_s <= ack_m;
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rq_m <= 1'b0;
      rq_s <= 1'b0;
      rq_d <= 1'b0;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      str_m <= 3'h0;
      str_s <= 3'h0;
    end else begin
      rq_m <= req_tog_reg;
      rq_s <= rq_m;
      rq_d <= rq_s;
      scl_m <= link.scl;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= link.sda;
      sda_s <= sda_m;
      sda_d <= sda_s;
      str_m <= chip_select_straps;
      str_s <= str_m;
    end
  end

  always_ff @(posedge link_clk) begin
    if (rq_s != rq_d) begin
      mem[la_reg] <= ld_reg;
    end
  end

  // Start and stop are only seen with SCL high on both samples; data moved by
  // this end only ever changes just after a falling SCL edge.
  assign rise    = scl_s && !scl_d;
  assign fall    = !scl_s && scl_d;
  assign start_c = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c  = scl_s && scl_d && !sda_d && sda_s;

  always_comb begin
    st_next   = st_reg;
    bit_next  = bit_reg;
    sh_next   = sh_reg;
    idx_next  = idx_reg;
    hi_next   = hi_reg;
    addr_next = addr_reg;
    oe_next   = oe_reg;
    rw_next   = rw_reg;
    mack_next = mack_reg;
    if (start_c) begin
      st_next  = ser_pkg::SER_D_RX;
      bit_next = 4'h0;
      idx_next = 2'h0;
      oe_next  = 1'b0;
    end else if (stop_c) begin
      st_next = ser_pkg::SER_D_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        ser_pkg::SER_D_IDLE: begin
          oe_next = 1'b0;
        end
        ser_pkg::SER_D_RX: begin
          if (rise && bit_reg != `SER_BITS_BYTE) begin
            sh_next  = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end else if (fall && bit_reg == `SER_BITS_BYTE) begin
            st_next = ser_pkg::SER_D_RX_ACK;
            oe_next = 1'b1;
            unique case (idx_reg)
              2'h0: begin
                rw_next = sh_reg[0];
                if (sh_reg[7:4] != `SER_DEV_CODE || sh_reg[3:1] != str_s) begin
                  st_next = ser_pkg::SER_D_IDLE;
                  oe_next = 1'b0;
                end
              end
              2'h1: hi_next = sh_reg[`SER_HI_W-1:0];
              2'h2: addr_next = {hi_next, sh_reg};
              default: begin
                st_next = ser_pkg::SER_D_IDLE;
                oe_next = 1'b0;
              end
            endcase
          end
        end
        ser_pkg::SER_D_RX_ACK: begin
          if (fall) begin
            oe_next  = 1'b0;
            bit_next = 4'h0;
            if (idx_reg == 2'h0 && rw_reg == `SER_DIR_READ) begin
              // Current and random reads both start from the counter.
              st_next   = ser_pkg::SER_D_TX;
              sh_next   = mem[addr_reg];
              oe_next   = !mem[addr_reg][7];
              addr_next = ADDR_W'(addr_reg + 1'b1);
            end else begin
              st_next  = ser_pkg::SER_D_RX;
              idx_next = idx_reg + 2'h1;
            end
          end
        end
        ser_pkg::SER_D_TX: begin
          if (fall) begin
            if (bit_reg == `SER_LAST_BIT) begin
              st_next = ser_pkg::SER_D_TX_ACK;
              oe_next = 1'b0;
            end else begin
              bit_next = bit_reg + 4'h1;
              sh_next  = {sh_reg[6:0], 1'b0};
              oe_next  = !sh_reg[6];
            end
          end
        end
        ser_pkg::SER_D_TX_ACK: begin
          if (rise) begin
            mack_next = !sda_s;
          end else if (fall) begin
            bit_next = 4'h0;
            if (mack_reg) begin
              // No new command is needed for the next byte.
              st_next   = ser_pkg::SER_D_TX;
              sh_next   = mem[addr_reg];
              oe_next   = !mem[addr_reg][7];
              addr_next = ADDR_W'(addr_reg + 1'b1);
            end else begin
              st_next = ser_pkg::SER_D_IDLE;
            end
          end
        end
        default: begin
          st_next = ser_pkg::SER_D_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // The counter has no other reset; it lives across transactions.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg   <= ser_pkg::SER_D_IDLE;
      bit_reg  <= 4'h0;
      sh_reg   <= 8'h00;
      idx_reg  <= 2'h0;
      hi_reg   <= '0;
      addr_reg <= '0;
      oe_reg   <= 1'b0;
      rw_reg   <= 1'b0;
      mack_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      idx_reg  <= idx_next;
      hi_reg   <= hi_next;
      addr_reg <= addr_next;
      oe_reg   <= oe_next;
      rw_reg   <= rw_next;
      mack_reg <= mack_next;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = oe_reg;
endmodule

// ==== logic/ser_host_ctrl.sv ====
// Purpose: Controller end that runs current-address, random and sequential reads.
// Assumes: SCL is made here from clk by a quarter-period divider.
// Notes: A missing acknowledge on any sent byte ends the transfer with a stop.
`timescale 1ns/10ps
`include "ser_defines.svh"
module ser_host_ctrl #(
  parameter int ADDR_W  = `SER_ADDR_W,
  parameter int QTR_CYC = `SER_QTR_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Command
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic              cmd_random,
  input  wire logic [2:0]        cmd_sel,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]        cmd_count,
  // Results
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  output logic                   done,
  output logic                   nack_err,
  // Link
  ser_link_if.host               link
);
  ser_pkg::ser_host_st_e st_reg, st_next;
  logic [15:0] div_reg, div_next;
  logic [1:0]  q_reg, q_next;
  logic [3:0]  bit_reg, bit_next;
  logic [2:0]  seq_reg, seq_next;
  logic [7:0]  sh_reg, sh_next;
  logic [7:0]  left_reg, left_next;
  logic        rx_reg, rx_next;
  logic        scl_reg, scl_next;
  logic        pull_reg, pull_next;
  logic        err_reg, err_next;
  logic [2:0]  sel_reg, sel_next;
  logic [ADDR_W-1:0] a_reg, a_next;
  logic [7:0]  rdd_reg, rdd_next;
  logic        rdv_reg, rdv_next;
  logic        done_reg, done_next;
  logic        sda_m, sda_s;
  logic        tick;
  logic [7:0]  dev_byte_w, dev_byte_r;

  assign tick = (div_reg == 16'(QTR_CYC - 1));
  assign cmd_ready = (st_reg == ser_pkg::SER_H_IDLE);
  assign dev_byte_w = {`SER_DEV_CODE, sel_reg, `SER_DIR_WRITE};
  assign dev_byte_r = {`SER_DEV_CODE, sel_reg, `SER_DIR_READ};

  always_comb begin
    st_next   = st_reg;
    div_next  = tick ? 16'h0000 : div_reg + 16'h0001;
    q_next    = q_reg;
    bit_next  = bit_reg;
    seq_next  = seq_reg;
    sh_next   = sh_reg;
    left_next = left_reg;
    rx_next   = rx_reg;
    scl_next  = scl_reg;
    pull_next = pull_reg;
    err_next  = err_reg;
    sel_next  = sel_reg;
    a_next    = a_reg;
    rdd_next  = rdd_reg;
    rdv_next  = 1'b0;
    done_next = 1'b0;
    unique case (st_reg)
      ser_pkg::SER_H_IDLE: begin
        scl_next = 1'b1;
        pull_next = 1'b0;
        div_next = 16'h0000;
        q_next = 2'h0;
        if (cmd_valid) begin
          st_next = ser_pkg::SER_H_START;
          sel_next = cmd_sel;
          a_next = cmd_addr;
          left_next = cmd_count;
          err_next = 1'b0;
          rx_next = 1'b0;
          seq_next = cmd_random ? 3'h0 : 3'h3;
        end
      end
      ser_pkg::SER_H_START: if (tick) begin
        q_next = q_reg + 2'h1;
        unique case (q_reg)
          2'h0: begin
            scl_next  = 1'b0;
            pull_next = 1'b0;
          end
          2'h1: scl_next = 1'b1;
          2'h2: pull_next = 1'b1;
          2'h3: begin
            scl_next = 1'b0;
            st_next = ser_pkg::SER_H_BYTE;
            bit_next = 4'h0;
            sh_next = (seq_reg == 3'h0) ? dev_byte_w : dev_byte_r;
          end
        endcase
      end
      ser_pkg::SER_H_BYTE: if (tick) begin
        q_next = q_reg + 2'h1;
        unique case (q_reg)
          2'h0: begin
            // Data moves only in the low phase of SCL.
            if (bit_reg == `SER_BITS_BYTE) begin
              pull_next = rx_reg && left_reg != 8'h01;
            end else begin
              pull_next = !rx_reg && !sh_reg[7];
            end
          end
          2'h1: scl_next = 1'b1;
          2'h2: begin
            if (bit_reg == `SER_BITS_BYTE) begin
              err_next = !rx_reg && sda_s;
            end else begin
              sh_next = {sh_reg[6:0], rx_reg ? sda_s : 1'b0};
            end
          end
          2'h3: begin
            scl_next = 1'b0;
            bit_next = bit_reg + 4'h1;
            if (bit_reg == `SER_BITS_BYTE) begin
              bit_next = 4'h0;
              if (rx_reg) begin
                rdv_next = 1'b1;
                rdd_next = sh_reg;
                left_next = left_reg - 8'h01;
                if (left_reg == 8'h01) st_next = ser_pkg::SER_H_STOP;
              end else if (err_reg) begin
                st_next = ser_pkg::SER_H_STOP;
              end else begin
                seq_next = seq_reg + 3'h1;
                unique case (seq_reg)
                  3'h0: sh_next = {2'b00, a_reg[ADDR_W-1:8]};
                  3'h1: sh_next = a_reg[7:0];
                  3'h2: st_next = ser_pkg::SER_H_START;
                  default: rx_next = 1'b1;
                endcase
              end
            end
          end
        endcase
      end
      ser_pkg::SER_H_STOP: if (tick) begin
        q_next = q_reg + 2'h1;
        unique case (q_reg)
          2'h0: begin
            scl_next  = 1'b0;
            pull_next = 1'b1;
          end
          2'h1: scl_next = 1'b1;
          2'h2: pull_next = 1'b0;
          2'h3: begin
            st_next   = ser_pkg::SER_H_IDLE;
            done_next = 1'b1;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg   <= ser_pkg::SER_H_IDLE;
      div_reg  <= 16'h0000;
      q_reg    <= 2'h0;
      bit_reg  <= 4'h0;
      seq_reg  <= 3'h0;
      sh_reg   <= 8'h00;
      left_reg <= 8'h00;
      rx_reg   <= 1'b0;
      scl_reg  <= 1'b1;
      pull_reg <= 1'b0;
      err_reg  <= 1'b0;
      sel_reg  <= 3'h0;
      a_reg    <= '0;
      rdd_reg  <= 8'h00;
      rdv_reg  <= 1'b0;
      done_reg <= 1'b0;
      sda_m    <= 1'b1;
      sda_s    <= 1'b1;
    end else begin
      st_reg   <= st_next;
      div_reg  <= div_next;
      q_reg    <= q_next;
      bit_reg  <= bit_next;
      seq_reg  <= seq_next;
      sh_reg   <= sh_next;
      left_reg <= left_next;
      rx_reg   <= rx_next;
      scl_reg  <= scl_next;
      pull_reg <= pull_next;
      err_reg  <= err_next;
      sel_reg  <= sel_next;
      a_reg    <= a_next;
      rdd_reg  <= rdd_next;
      rdv_reg  <= rdv_next;
      done_reg <= done_next;
      sda_m    <= link.sda;
      sda_s    <= sda_m;
    end
  end

  assign link.scl         = scl_reg;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = pull_reg;
  assign rd_valid = rdv_reg;
  assign rd_data  = rdd_reg;
  assign done     = done_reg;
  assign nack_err = err_reg && done_reg;
endmodule

// ==== logic/ser_link_if.sv ====
// Purpose: Two-wire link between controller and EEPROM read path.
// Assumes: Open-drain data line; both ends only ever pull low.
// Notes: The wired level is resolved here from the enables.
`timescale 1ns/10ps
interface ser_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// ==== logic/ser_pkg.sv ====
// Purpose: State types for both ends of the two-wire read path.
// Assumes: Used by name with the package prefix.
// Notes: Binary codes are written out.
package ser_pkg;
  typedef enum logic [2:0] {
    SER_D_IDLE   = 3'h0,
    SER_D_RX     = 3'h1,
    SER_D_RX_ACK = 3'h2,
    SER_D_TX     = 3'h3,
    SER_D_TX_ACK = 3'h4
  } ser_dev_st_e;
  typedef enum logic [1:0] {
    SER_H_IDLE  = 2'h0,
    SER_H_START = 2'h1,
    SER_H_BYTE  = 2'h2,
    SER_H_STOP  = 2'h3
  } ser_host_st_e;
endpackage
